// ---- cwm_bus_node_model.sv ----
// bus node model: wake events and error count seen by the decoder
`timescale 1ns/1ps
module cwm_bus_node_model
  import cwm_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [2:0] send,
  input wire logic quiet,
  output cwm_wake_evt_t wake_evt,
  output logic [5:0] err_count
);
  logic ovf_q;
  // send: 1 frame, 2 pattern, 3 error burst, 4 other source
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wake_evt <= '0;
      err_count <= 6'h00;
      ovf_q <= 1'b0;
    end else begin
      wake_evt.frame <= (send == 3'h1);
      wake_evt.pattern <= (send == 3'h2);
      ovf_q <= (send == 3'h3);
      wake_evt.err_ovf <= ovf_q; // count leads the overflow
      wake_evt.other <= (send == 3'h4);
      wake_evt.silence <= quiet;
      if (send == 3'h3) err_count <= ERRCNT_OVF;
    end
  end
endmodule : cwm_bus_node_model

// ---- cwm_mode_ctrl.sv ----
// device and transceiver mode control with wake reporting and osc trim
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// - in Sleep the transceiver is only off, wake-capable or selective-wake
// - wake frame in Sleep gives Restart, config_valid cleared, code 101
// - after a wake, Normal needs a write to a non-wake code and back to rearm
// - each entry into Sleep rearms the transceiver automatically
// - Sleep entry: off codes unchanged; 001/010/011 become wake with 001
// - Sleep entry with 1x1/110: selective wake unless error; code 101
// - in and after Restart only off, wake or selective-wake after frame
// - Restart from Normal: 001/010/011 to wake 001, 000 stays off, selective codes 101 + error
// - Sleep wake flags: can wake, pattern and frame flags by cause
// - counter overflow wake sets can wake and error, count reads 100000
// - frame inside silence time sets both flags, else pattern flag stays clear
// - pattern flag may stay clear after silence, e.g. on overflow
// - Fail-Safe entry forces plain wake-capable, selective wake off
// - can wake restarts from Sleep, interrupts in Normal or Stop
// - bit timing register sets quanta per bit and sampling point
// - a config bit picks the receiver path feeding the frame decoder
// - frames match identifier, mask, length code and data registers
// - with measure enabled and transceiver off, pulse width on tx input counted and shown
// - trim writes act only with unlock 11 and measure on; end with 00
// - 3-bit code: off, wake, rx-only, normal, off, sel, rx-sel, norm-sel
// - error bit 0 means selective wake enabled; 1 stops frame detection
module cwm_mode_ctrl
  import cwm_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire cwm_wake_evt_t wake_evt,
  input wire logic [5:0] err_count,
  input wire logic restart_req,
  input wire logic fail_safe_req,
  input wire logic can_tx_input,
  output cwm_dev_t dev_mode,
  output cwm_xcvr_t xcvr_mode,
  output logic sel_wake_en,
  output cwm_filter_cfg_t filter_cfg,
  output logic [7:0] osc_trim_value,
  output logic can_wake_irq
);

  // ************************************************
  // state
  // ************************************************
  cwm_dev_t dev_q;
  cwm_xcvr_t xcvr_q;
  logic [2:0] can_mode_bits_q;
  logic config_valid_q, sys_error_q, rx_sel_q, osc_en_q;
  logic sel_wake_q, armed_q, rearm_pend_q;
  logic can_wake_flag_q, wake_pattern_flag_q, wake_frame_flag_q;
  logic [5:0] frame_error_count_q;
  logic [7:0] cfg_q [CFG_BYTES];
  logic [7:0] rst_cnt_q;
  logic [15:0] osc_cnt_q, osc_res_q;
  logic tx_prev_q, irq_q;
  logic [7:0] trim_q, rdata_q;
  logic [1:0] unlock_q;

  // ************************************************
  // decode and events
  // ************************************************
  logic wr_mode, wr_dev, wr_stat, wr_cfg, wr_trim, wr_unlock;
  logic in_norm, sleep_entry, stop_entry, wake_entry, fs_entry;
  logic restart_norm, is_sel_code, code_wk;
  logic sleep_pat, sleep_frame, sleep_ovf, sleep_can, sleep_other;
  logic fs_wake, run_frame, run_pat, run_can, ev_can;
  logic [4:0] cfg_idx;

  assign wr_mode = reg_wr && reg_addr == OFS_MODE;
  assign wr_dev = reg_wr && reg_addr == OFS_DEVCMD;
  assign wr_stat = reg_wr && reg_addr == OFS_STATUS;
  assign wr_cfg = reg_wr && reg_addr >= OFS_CFG_FIRST
                  && reg_addr <= OFS_CFG_LAST;
  assign wr_trim = reg_wr && reg_addr == OFS_TRIM;
  assign wr_unlock = reg_wr && reg_addr == OFS_UNLOCK;
  assign cfg_idx = 5'(reg_addr - OFS_CFG_FIRST);
  assign in_norm = dev_q == DEV_NORMAL;

  // selective codes are 101, 110, 111; 100 is an off code
  assign is_sel_code = can_mode_bits_q[2] && can_mode_bits_q != CODE_OFF1;
  // written code that leaves the transceiver wake capable
  assign code_wk = reg_wdata[2:0] == CODE_WAKE
                   || (reg_wdata[2] && reg_wdata[2:0] != CODE_OFF1);

  // device mode commands are only honoured from Normal, except Stop->Normal
  assign sleep_entry = in_norm && wr_dev && reg_wdata[1:0] == CMD_SLEEP;
  assign stop_entry = in_norm && wr_dev && reg_wdata[1:0] == CMD_STOP;
  assign wake_entry = dev_q == DEV_STOP && wr_dev
                      && reg_wdata[1:0] == CMD_NORMAL;
  assign fs_entry = fail_safe_req && dev_q != DEV_FAILSAFE;
  assign restart_norm = !fail_safe_req && restart_req
                        && (in_norm || dev_q == DEV_STOP);

  // sleep can wakes are only seen by an armed transceiver
  assign sleep_pat = dev_q == DEV_SLEEP && armed_q && xcvr_q == XCV_WAKE
                     && !sel_wake_q && wake_evt.pattern;
  assign sleep_frame = dev_q == DEV_SLEEP && armed_q && sel_wake_q
                       && wake_evt.frame;
  assign sleep_ovf = dev_q == DEV_SLEEP && armed_q && sel_wake_q
                     && !wake_evt.frame && wake_evt.err_ovf;
  assign sleep_can = sleep_pat || sleep_frame || sleep_ovf;
  assign sleep_other = dev_q == DEV_SLEEP && !sleep_can && wake_evt.other;
  assign fs_wake = dev_q == DEV_FAILSAFE
                   && (wake_evt.pattern || wake_evt.other);

  // running modes report can wakes by interrupt and status flags, not by restart
  // a woken transceiver ignores frames until rearmed
  assign run_frame = (in_norm || dev_q == DEV_STOP) && sel_wake_q
                     && armed_q && wake_evt.frame;
  assign run_pat = dev_q == DEV_STOP && xcvr_q == XCV_WAKE && armed_q
                   && wake_evt.pattern;
  assign run_can = run_frame || run_pat;
  assign ev_can = sleep_can || run_can
                  || (dev_q == DEV_FAILSAFE && wake_evt.pattern);

  // ************************************************
  // device mode sequencer
  // ************************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dev_q <= DEV_NORMAL;
      rst_cnt_q <= 8'h00;
    end else begin
      case (dev_q)
        DEV_NORMAL: begin
          if (sleep_entry) begin
            dev_q <= DEV_SLEEP;
          end else if (stop_entry) begin
            dev_q <= DEV_STOP;
          end else if (restart_norm) begin
            dev_q <= DEV_RESTART;
          end
        end
        DEV_STOP: begin
          if (wake_entry) begin
            dev_q <= DEV_NORMAL;
          end else if (restart_norm) begin
            dev_q <= DEV_RESTART;
          end
        end
        DEV_SLEEP: begin
          if (sleep_can || sleep_other) begin
            dev_q <= DEV_RESTART;
          end
        end
        DEV_RESTART: begin
          if (rst_cnt_q == 8'(RESTART_CYCLES - 1)) begin
            dev_q <= DEV_NORMAL;
          end
        end
        DEV_FAILSAFE: begin
          if (fs_wake) begin
            dev_q <= DEV_RESTART;
          end
        end
        default: dev_q <= DEV_NORMAL;
      endcase
      if (fs_entry) begin
        dev_q <= DEV_FAILSAFE;
      end
      // restart length counter, idle outside restart
      rst_cnt_q <= (dev_q == DEV_RESTART) ? 8'(rst_cnt_q + 8'h01) : 8'h00;
    end
  end

  // ************************************************
  // transceiver mode, code bits and error bit
  // ************************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      can_mode_bits_q <= CODE_OFF0;
      config_valid_q <= 1'b0;
      sys_error_q <= 1'b0;
      rx_sel_q <= 1'b0;
      osc_en_q <= 1'b0;
      xcvr_q <= XCV_OFF;
      sel_wake_q <= 1'b0;
      armed_q <= 1'b1;
      rearm_pend_q <= 1'b0;
    end else if (fs_entry) begin
      xcvr_q <= XCV_WAKE;
      sel_wake_q <= 1'b0;
    end else if (sleep_entry) begin
      armed_q <= 1'b1;
      rearm_pend_q <= 1'b0;
      if (can_mode_bits_q == CODE_OFF0 || can_mode_bits_q == CODE_OFF1) begin
        xcvr_q <= XCV_OFF;
        sel_wake_q <= 1'b0;
      end else if (!can_mode_bits_q[2]) begin
        xcvr_q <= XCV_WAKE;
        sel_wake_q <= 1'b0;
        can_mode_bits_q <= CODE_WAKE;
      end else begin
        // failed config check falls back to plain wake
        xcvr_q <= XCV_WAKE;
        sel_wake_q <= !sys_error_q && config_valid_q;
        sys_error_q <= sys_error_q || !config_valid_q;
        can_mode_bits_q <= CODE_SELWAKE;
      end
    end else if (restart_norm) begin
      sel_wake_q <= 1'b0;
      if (can_mode_bits_q == CODE_OFF0 || can_mode_bits_q == CODE_OFF1) begin
        xcvr_q <= XCV_OFF;
      end else if (!can_mode_bits_q[2]) begin
        xcvr_q <= XCV_WAKE;
        can_mode_bits_q <= CODE_WAKE;
      end else begin
        xcvr_q <= XCV_WAKE;
        can_mode_bits_q <= CODE_SELWAKE;
        sys_error_q <= 1'b1;
      end
    end else if (sleep_can || run_can) begin
      // a woken transceiver stays put until rearmed
      armed_q <= 1'b0;
      if (sleep_frame) begin
        config_valid_q <= 1'b0;
      end
      if (sleep_ovf) begin
        sys_error_q <= 1'b1;
      end
    end else if (in_norm && wr_mode) begin
      can_mode_bits_q <= reg_wdata[2:0];
      config_valid_q <= reg_wdata[MODE_CFG_VALID];
      sys_error_q <= reg_wdata[MODE_SYS_ERR];
      rx_sel_q <= reg_wdata[MODE_RX_SEL];
      osc_en_q <= reg_wdata[MODE_OSC_EN];
      if (!code_wk) begin
        rearm_pend_q <= 1'b1;
      end else if (rearm_pend_q) begin
        armed_q <= 1'b1;
        rearm_pend_q <= 1'b0;
      end
    end else if (in_norm && wr_cfg) begin
      // changed filter data invalidates the config check
      config_valid_q <= 1'b0;
    end else if (in_norm || dev_q == DEV_STOP) begin
      // running modes follow the programmed code directly
      case (can_mode_bits_q[1:0])
        2'h1: xcvr_q <= XCV_WAKE;
        2'h2: xcvr_q <= XCV_RXONLY;
        2'h3: xcvr_q <= XCV_NORMAL;
        default: xcvr_q <= XCV_OFF;
      endcase
      sel_wake_q <= is_sel_code && !sys_error_q;
    end
  end

  // ************************************************
  // wake flags, error count and interrupt
  // ************************************************
  // software clears by writing ones; a same-cycle set wins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      can_wake_flag_q <= 1'b0;
      wake_pattern_flag_q <= 1'b0;
      wake_frame_flag_q <= 1'b0;
      frame_error_count_q <= 6'h00;
      irq_q <= 1'b0;
    end else begin
      can_wake_flag_q <= ev_can
                         || (can_wake_flag_q && !(wr_stat && reg_wdata[0]));
      // a frame inside the silence time also sets the pattern flag
      wake_pattern_flag_q <= sleep_pat || run_pat
        || ((sleep_frame || run_frame) && wake_evt.silence)
        || (wake_pattern_flag_q && !(wr_stat && reg_wdata[1]));
      // overflow wake sets no pattern flag by itself
      wake_frame_flag_q <= sleep_frame || run_frame
        || (wake_frame_flag_q && !(wr_stat && reg_wdata[2]));
      // count frozen while a wake is reported
      if (sleep_ovf) begin
        frame_error_count_q <= ERRCNT_OVF;
      end else if (!can_wake_flag_q) begin
        frame_error_count_q <= err_count;
      end
      irq_q <= run_can;
    end
  end

  // ************************************************
  // wake filter configuration bytes
  // ************************************************
  // writes only in Normal so the decoder never sees a half update
  for (genvar i = 0; i < CFG_BYTES; i++) begin : g_cfg
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        cfg_q[i] <= (i == 0) ? BIT_TIMING_RST : 8'h00;
      end else if (in_norm && wr_cfg && cfg_idx == 5'(i)) begin
        cfg_q[i] <= reg_wdata;
      end
    end
  end

  // ************************************************
  // oscillator measurement and trim
  // ************************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_prev_q <= 1'b0;
      osc_cnt_q <= 16'h0000;
      osc_res_q <= 16'h0000;
    end else begin
      tx_prev_q <= can_tx_input;
      if (osc_en_q && xcvr_q == XCV_OFF) begin
        if (can_tx_input && !tx_prev_q) begin
          osc_cnt_q <= 16'h0001;
        end else if (can_tx_input && osc_cnt_q != 16'hffff) begin
          osc_cnt_q <= 16'(osc_cnt_q + 16'h0001);
        end else if (!can_tx_input && tx_prev_q) begin
          osc_res_q <= osc_cnt_q;
        end
      end
    end
  end

  // trim register sits behind the two-bit unlock key
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      unlock_q <= 2'h0;
      trim_q <= TRIM_RST;
    end else begin
      if (wr_unlock) begin
        unlock_q <= reg_wdata[1:0];
      end
      if (wr_trim && unlock_q == TRIM_KEY && osc_en_q) begin
        trim_q <= reg_wdata;
      end
    end
  end

  // ************************************************
  // register read port
  // ************************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      if (wr_cfg || (reg_addr >= OFS_CFG_FIRST
                     && reg_addr <= OFS_CFG_LAST)) begin
        rdata_q <= cfg_q[cfg_idx];
      end else begin
        case (reg_addr)
          OFS_MODE: rdata_q <= {1'b0, osc_en_q, rx_sel_q, sys_error_q,
                                config_valid_q, can_mode_bits_q};
          OFS_DEVCMD: rdata_q <= {3'h0, armed_q, sel_wake_q, 3'(dev_q)};
          OFS_STATUS: rdata_q <= {3'h0, 2'(xcvr_q), wake_frame_flag_q,
                                  wake_pattern_flag_q, can_wake_flag_q};
          OFS_ERRCNT: rdata_q <= {2'h0, frame_error_count_q};
          OFS_OSC_HIGH: rdata_q <= osc_res_q[15:8];
          OFS_OSC_LOW: rdata_q <= osc_res_q[7:0];
          OFS_TRIM: rdata_q <= trim_q;
          OFS_UNLOCK: rdata_q <= {6'h00, unlock_q};
          default: rdata_q <= 8'h00;
        endcase
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign reg_rdata = rdata_q;
  assign dev_mode = dev_q;
  assign xcvr_mode = xcvr_q;
  assign sel_wake_en = sel_wake_q && armed_q;
  assign osc_trim_value = trim_q;
  assign can_wake_irq = irq_q;
  // decoder setup; bit timing holds quanta and sampling point
  assign filter_cfg = {rx_sel_q, cfg_q[0], cfg_q[1], cfg_q[2],
                       cfg_q[3], cfg_q[4], cfg_q[5], cfg_q[6],
                       cfg_q[7], cfg_q[8], cfg_q[9], cfg_q[10],
                       cfg_q[11], cfg_q[12], cfg_q[13], cfg_q[14],
                       cfg_q[15], cfg_q[16], cfg_q[17], cfg_q[18],
                       cfg_q[19]};

  // ************************************************
  // checks
  // ************************************************
  chk_sleep_xcvr_legal: assert property (
    @(posedge clock) disable iff (!arst_n)
    dev_q == DEV_SLEEP |-> xcvr_q == XCV_OFF || xcvr_q == XCV_WAKE)
    else $error("active transceiver mode during sleep");

  chk_sleep_map_low: assert property (
    @(posedge clock) disable iff (!arst_n)
    sleep_entry && !fail_safe_req && !can_mode_bits_q[2]
    && can_mode_bits_q != CODE_OFF0
    |=> can_mode_bits_q == CODE_WAKE && xcvr_q == XCV_WAKE && !sel_wake_en)
    else $error("low code not mapped to wake on sleep");

  chk_sleep_map_sel: assert property (
    @(posedge clock) disable iff (!arst_n)
    sleep_entry && !fail_safe_req && is_sel_code && !sys_error_q
    && config_valid_q |=> sel_wake_en && can_mode_bits_q == CODE_SELWAKE)
    else $error("selective code not mapped on sleep");

  chk_restart_normal: assert property (
    @(posedge clock) disable iff (!arst_n)
    restart_norm && !fs_entry && !sleep_entry && is_sel_code |=> sys_error_q
    && can_mode_bits_q == CODE_SELWAKE && !sel_wake_en && xcvr_q == XCV_WAKE)
    else $error("restart from normal mapping wrong");

  chk_frame_wake: assert property (
    @(posedge clock) disable iff (!arst_n)
    sleep_frame && !fail_safe_req |=> dev_q == DEV_RESTART && !config_valid_q
    && wake_frame_flag_q && can_wake_flag_q
    && sys_error_q == $past(sys_error_q))
    else $error("wake frame handling wrong");

  chk_ovf_count: assert property (
    @(posedge clock) disable iff (!arst_n)
    sleep_ovf && !fail_safe_req |=> frame_error_count_q == ERRCNT_OVF
    && sys_error_q && can_wake_flag_q ##1 frame_error_count_q == ERRCNT_OVF)
    else $error("overflow wake not reported");

  chk_failsafe_wake: assert property (
    @(posedge clock) disable iff (!arst_n)
    fs_entry |=> dev_q == DEV_FAILSAFE && xcvr_q == XCV_WAKE && !sel_wake_en)
    else $error("fail-safe entry did not force wake mode");

  chk_trim_locked: assert property (
    @(posedge clock) disable iff (!arst_n)
    wr_trim && !(unlock_q == TRIM_KEY && osc_en_q) |=> $stable(trim_q))
    else $error("trim changed while locked");

  chk_sleep_rearm: assert property (
    @(posedge clock) disable iff (!arst_n)
    sleep_entry && !fail_safe_req |=> armed_q && dev_q == DEV_SLEEP)
    else $error("sleep entry did not rearm");

  chk_run_irq: assert property (
    @(posedge clock) disable iff (!arst_n)
    run_can |=> can_wake_irq && can_wake_flag_q
    ##1 !can_wake_irq || $past(run_can))
    else $error("can wake interrupt missing");

endmodule : cwm_mode_ctrl

// ---- cwm_pkg.sv ----
// constants, types and register map of the wake mode controller
package cwm_pkg;

  // ************************************************
  // timing
  // ************************************************
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned RESTART_TIME_NS = 40;
  localparam int unsigned RESTART_CYCLES = (RESTART_TIME_NS * 1000)
                                           / CLK_PERIOD_PS;

  // ************************************************
  // register offsets
  // ************************************************
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_DEVCMD = 8'h01;
  localparam logic [7:0] OFS_STATUS = 8'h02;
  localparam logic [7:0] OFS_ERRCNT = 8'h03;
  localparam logic [7:0] OFS_CFG_FIRST = 8'h04;
  localparam logic [7:0] OFS_CFG_LAST = 8'h17;
  localparam logic [7:0] OFS_OSC_HIGH = 8'h18;
  localparam logic [7:0] OFS_OSC_LOW = 8'h19;
  localparam logic [7:0] OFS_TRIM = 8'h1a;
  localparam logic [7:0] OFS_UNLOCK = 8'h1b;
  localparam int unsigned CFG_BYTES = 20;

  // ************************************************
  // field positions and reset values
  // ************************************************
  localparam int unsigned MODE_CFG_VALID = 3;
  localparam int unsigned MODE_SYS_ERR = 4;
  localparam int unsigned MODE_RX_SEL = 5;
  localparam int unsigned MODE_OSC_EN = 6;
  localparam logic [7:0] BIT_TIMING_RST = 8'h33;
  localparam logic [5:0] ERRCNT_OVF = 6'h20;
  localparam logic [1:0] TRIM_KEY = 2'h3;
  localparam logic [7:0] TRIM_RST = 8'h80;

  // ************************************************
  // transceiver mode codes and device commands
  // ************************************************
  localparam logic [2:0] CODE_OFF0 = 3'h0;
  localparam logic [2:0] CODE_WAKE = 3'h1;
  localparam logic [2:0] CODE_RXONLY = 3'h2;
  localparam logic [2:0] CODE_NORMAL = 3'h3;
  localparam logic [2:0] CODE_OFF1 = 3'h4;
  localparam logic [2:0] CODE_SELWAKE = 3'h5;
  localparam logic [1:0] CMD_NORMAL = 2'h0;
  localparam logic [1:0] CMD_STOP = 2'h1;
  localparam logic [1:0] CMD_SLEEP = 2'h2;

  typedef enum logic [2:0] {
    DEV_NORMAL, DEV_STOP, DEV_SLEEP, DEV_RESTART, DEV_FAILSAFE
  } cwm_dev_t;

  typedef enum logic [1:0] {
    XCV_OFF, XCV_WAKE, XCV_RXONLY, XCV_NORMAL
  } cwm_xcvr_t;

  // one-cycle events from the frame decoder and the wake sources, plus the silence level
  typedef struct packed {
    logic frame;
    logic pattern;
    logic err_ovf;
    logic other;
    logic silence;
  } cwm_wake_evt_t;

  // filter and timing setup handed to the frame decoder
  typedef struct packed {
    logic rx_select;
    logic [7:0] bit_timing;
    logic [7:0] clk_recovery;
    logic [7:0] clk_limits;
    logic [31:0] ident;
    logic [31:0] ident_mask;
    logic [7:0] length_code;
    logic [63:0] data_bytes;
  } cwm_filter_cfg_t;

endpackage : cwm_pkg

// ---- testbench.sv ----
// self-checking bench for the wake mode controller
`timescale 1ns/1ps
module testbench;
  import cwm_pkg::*;
  logic clock = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, rst_req = 0;
  logic fs_req = 0, tx_in = 0, quiet = 0, sel, irq;
  logic [2:0] send = 0;
  logic [7:0] addr = 0, wdata = 0, rdata, trim, v, w;
  logic [5:0] frame_error_count;
  cwm_wake_evt_t evt;
  cwm_dev_t dev;
  cwm_xcvr_t xcvr;
  cwm_filter_cfg_t cfg;
  int errors = 0, tests_run = 0, cycles = 0, irqs = 0, n;
  int seed = 32'h7a50;
  cwm_mode_ctrl i_cwm_mode_ctrl(.clock(clock), .arst_n(arst_n),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .wake_evt(evt), .err_count(frame_error_count),
    .restart_req(rst_req), .fail_safe_req(fs_req), .can_tx_input(tx_in),
    .dev_mode(dev), .xcvr_mode(xcvr), .sel_wake_en(sel),
    .filter_cfg(cfg), .osc_trim_value(trim), .can_wake_irq(irq));
  cwm_bus_node_model i_cwm_bus_node_model(.clock(clock), .arst_n(arst_n),
    .send(send), .quiet(quiet), .wake_evt(evt), .err_count(frame_error_count));
  // ************************************************
  // clock, guard and helpers
  // ************************************************
  initial begin
    forever #2 clock = ~clock;
  end
  // irq is a one-cycle pulse, so it is counted rather than sampled
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (irq === 1'b1) irqs <= irqs + 1;
    if (cycles > 20000) begin
      errors = errors + 1;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task automatic ev(input logic [2:0] c);
    @(posedge clock);
    send <= c;
    @(posedge clock);
    send <= 3'h0;
    repeat (3) @(posedge clock);
    #1;
  endtask : ev
  task automatic to_normal();
    #1;
    for (n = 0; n < 100 && dev !== DEV_NORMAL; n++) begin
      @(posedge clock);
      #1;
    end
    check(8'(dev), 8'(DEV_NORMAL));
    wr(OFS_STATUS, 8'h07);
  endtask : to_normal
  task automatic sleep_in(input logic [7:0] m);
    wr(OFS_MODE, m);
    wr(OFS_DEVCMD, {6'h00, CMD_SLEEP});
    repeat (2) @(posedge clock);
    #1;
  endtask : sleep_in
  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    check(cfg.bit_timing, BIT_TIMING_RST);
    rd(OFS_TRIM);
    check(v, TRIM_RST);
    rd(8'h30);
    check(v, 8'h00);
    // every code, with and without the error bit; bit 3 is config valid
    for (int c = 0; c < 16; c++) begin
      sleep_in({3'h0, c[3], 1'b1, c[2:0]});
      check(8'(xcvr), (c % 4 == 0) ? 8'h00 : 8'h01);
      check(8'(sel), 8'(c > 4 && c < 8));
      wr(OFS_MODE, 8'h0b);
      rd(OFS_MODE);
      w = (c % 8 == 2 || c % 8 == 3) ? 8'h01 : (c % 8 > 4 ? 8'h05 : 8'(c % 8));
      check(8'(v[2:0]), w);
      ev(3'h4);
      rd(OFS_STATUS);
      check(8'(v[0]), 8'h00);
      to_normal();
    end
    sleep_in(8'h0d);
    ev(3'h1);
    check(8'(dev), 8'(DEV_RESTART));
    rd(OFS_STATUS);
    check(8'(v[2:0]), 8'h05);
    rd(OFS_MODE);
    check(v & 8'h1f, 8'h05);
    to_normal();
    ev(3'h1);
    check(8'(irqs), 8'h00);
    wr(OFS_MODE, 8'h08);
    wr(OFS_MODE, 8'h0d);
    ev(3'h1);
    check(8'(irqs), 8'h01);
    wr(OFS_STATUS, 8'h07);
    sleep_in(8'h0d);
    ev(3'h3);
    rd(OFS_STATUS);
    check(v & 8'h05, 8'h01);
    rd(OFS_ERRCNT);
    check(v, 8'h20);
    rd(OFS_MODE);
    check(v & 8'h17, 8'h15);
    to_normal();
    wr(OFS_MODE, 8'h08);
    quiet <= 1'b1;
    sleep_in(8'h0d);
    ev(3'h1);
    rd(OFS_STATUS);
    check(8'(v[2:0]), 8'h07);
    to_normal();
    quiet <= 1'b0;
    wr(OFS_MODE, 8'h0e);
    @(posedge clock);
    rst_req <= 1'b1;
    @(posedge clock);
    rst_req <= 1'b0;
    to_normal();
    rd(OFS_MODE);
    check(v & 8'h17, 8'h15);
    check(8'(xcvr) | 8'(sel) << 4, 8'h01);
    // plain wake mode in sleep, woken by a wake pattern
    sleep_in(8'h09);
    ev(3'h2);
    rd(OFS_STATUS);
    check(8'(v[2:0]), 8'h03);
    to_normal();
    wr(OFS_MODE, 8'h08);
    wr(OFS_MODE, 8'h48);
    n = 20 + ($random(seed) & 8'h3f);
    @(posedge clock);
    tx_in <= 1'b1;
    repeat (n) @(posedge clock);
    tx_in <= 1'b0;
    rd(OFS_OSC_HIGH);
    w = v;
    rd(OFS_OSC_LOW);
    check(8'({w, v} + 1 - n <= 2), 8'h01);
    w = $random(seed) | 8'h01;
    wr(OFS_TRIM, w);
    #1 check(trim, TRIM_RST);
    wr(OFS_UNLOCK, 8'h03);
    wr(OFS_TRIM, w);
    #1 check(trim, w);
    wr(OFS_UNLOCK, 8'h00);
    wr(OFS_TRIM, ~w);
    #1 check(trim, w);
    @(posedge clock);
    fs_req <= 1'b1;
    @(posedge clock);
    fs_req <= 1'b0;
    repeat (2) @(posedge clock);
    #1 check(8'(xcvr) | 8'(sel) << 4, 8'h01);
    tally_and_finish();
  end
endmodule : testbench
